// [tec_pkg.sv]
// Package for the T1 receive error counter and event word block.
// Assumes one 100 MHz clock and an AXI4-Lite master with 32-bit data.
package tec_pkg;

  // Register indices; the byte address is four times the index
  localparam int unsigned    IDX_W         = 8;
  localparam logic [7:0]     IDX_LCV_HIGH  = 8'h16;
  localparam logic [7:0]     IDX_LCV_LOW   = 8'h17;
  localparam logic [7:0]     IDX_CRC_HIGH  = 8'h18;
  localparam logic [7:0]     IDX_CRC_LOW   = 8'h19;
  localparam logic [7:0]     IDX_SYNC_WORD = 8'h1b;
  localparam logic [7:0]     IDX_ERR_WORD  = 8'h1c;
  localparam logic [7:0]     IDX_CTRL      = 8'h20;
  localparam logic [7:0]     IDX_SYNC_MASK = 8'h2b;
  localparam logic [7:0]     IDX_ERR_MASK  = 8'h2c;

  // Sync and alarm event word bit positions
  localparam int unsigned    SW_TSYNC      = 7;
  localparam int unsigned    SW_MFSYNC     = 6;
  localparam int unsigned    SW_LINK_MSG   = 5;
  localparam int unsigned    SW_ALL_ONES   = 4;
  localparam int unsigned    SW_SIG_LOSS   = 3;
  localparam int unsigned    SW_SEVERE     = 2;
  localparam int unsigned    SW_TX_SLIP    = 1;
  localparam int unsigned    SW_RX_SLIP    = 0;

  // Error event word bit positions; bit 0 carries nothing
  localparam int unsigned    EW_FBIT       = 7;
  localparam int unsigned    EW_CRC        = 6;
  localparam int unsigned    EW_YELLOW     = 5;
  localparam int unsigned    EW_ALIGN      = 4;
  localparam int unsigned    EW_LCV        = 3;
  localparam int unsigned    EW_PRBS       = 2;
  localparam int unsigned    EW_DENSITY    = 1;
  localparam int unsigned    EW_UNUSED     = 0;

  // Control register fields and reset values
  localparam int unsigned    CTRL_EXZ      = 0;
  localparam int unsigned    CTRL_ZSUB     = 1;
  localparam logic [7:0]     CTRL_RST      = 8'h00;
  localparam logic [7:0]     MASK_RST      = 8'hff;
  localparam logic [7:0]     ERR_USED      = 8'hfe;

  // Line monitor thresholds
  localparam logic [4:0]     ZERO_RUN_PLAIN = 5'h10;
  localparam logic [4:0]     ZERO_RUN_ZSUB  = 5'h08;
  localparam int unsigned    DENS_N_MAX     = 23;
  localparam int unsigned    DENS_WIN_MAX   = 8 * (DENS_N_MAX + 1);

  // AXI responses
  localparam logic [1:0]     RESP_OKAY     = 2'h0;
  localparam logic [1:0]     RESP_SLVERR   = 2'h2;

  // Event inputs from the receive detectors, all synchronous to aclk
  typedef struct packed {
    logic terminal_sync;          // Level: terminal frame sync held
    logic multiframe_sync;        // Level: multiframe sync held
    logic bit_oriented_link_message_new;  // Pulse: new message accepted
    logic bit_oriented_link_message_stop; // Pulse: current message ended
    logic all_ones;               // Level: all-ones received
    logic signal_loss;            // Level: loss of signal
    logic framing_bit_strobe;     // Pulse: one framing bit checked
    logic framing_bit_error;      // With strobe: that bit was wrong
    logic tx_slip;                // Pulse: transmit buffer slip
    logic rx_slip;                // Pulse: receive buffer slip
    logic crc_fail;               // Pulse: multiframe CRC-6 failed
    logic yellow_alarm;           // Pulse: yellow alarm detected
    logic reframe_shifted;        // Pulse: reframe ended at new alignment
    logic bipolar_violation;      // Pulse: bipolar violation seen
    logic violation_in_code_word; // With violation: part of B8ZS word
    logic excess_zeros;           // Pulse: excess zeros seen
    logic test_sequence_error;    // Pulse: PRBS error on tested channel
    logic rx_bit_strobe;          // Pulse: one line bit received
    logic rx_bit_mark;            // With strobe: bit was a one
  } tec_events_s;

  // Write channel progress
  typedef enum logic [1:0] {
    WR_COLLECT = 2'b00,
    WR_RESPOND = 2'b01
  } tec_wr_state_e;

endpackage : tec_pkg

// [tec_error_counters.sv]
// T1 receive error counters and the two read-to-clear event words.
// Assumes AXI4-Lite on aclk, event inputs synchronous to aclk.
//
// The implementer's own choice: the AXI4-Lite slave port.

// Operation
// - Keep 16-bit line violation count; low byte readable.
// - High byte of line violation count readable one index below low byte.
// - Excess-zero control low: count only violations outside zero-substitution words.
// - Excess-zero control high: count violations and excess zeros.
// - Keep 16-bit CRC-6 error count readable as high and low bytes.
// - Status bits set only when unmasked; reading a word clears it.
// - Sync word bit 7 sets on terminal sync change.
// - Sync word bit 6 sets on multiframe sync change.
// - Sync word bit 5 sets on new link message or message stop.
// - Sync word bit 4 sets on all-ones change.
// - Sync word bit 3 sets on any loss-of-signal change.
// - Sync word bit 2 sets on two framing errors within six bits.
// - Sync word bit 1 sets on transmit buffer slip.
// - Sync word bit 0 sets on receive buffer slip.
// - Error word bit 7 sets on framing bit error while synchronized.
// - Error word bit 6 sets on CRC-6 failure.
// - Error word bit 5 sets on yellow alarm.
// - Error word bit 4 sets when reframe changes alignment.
// - Error word bit 3 sets on each counted line violation.
// - Error word bit 2 sets on test sequence error.
// - Error word bit 1 sets on zero runs, or on low pulse density with zero substitution off.
module tec_error_counters #(
  parameter int unsigned ADDR_W = 12,
  parameter int unsigned CNT_W  = 16
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire tec_pkg::tec_events_s ev,
  output logic                      event_irq
);

  // Refuse shapes the byte registers cannot show
  if (CNT_W < 9 || CNT_W > 16 || ADDR_W < tec_pkg::IDX_W + 2) begin : g_bad_param
    $error("tec_error_counters: CNT_W must be 9..16, ADDR_W at least IDX_W+2");
  end

  tec_pkg::tec_wr_state_e   wr_state_q;
  logic                     aw_held_q;
  logic                     w_held_q;
  logic [ADDR_W-1:0]        aw_addr_q;
  logic [7:0]               wdata_q;
  logic                     wlane_q;
  logic [1:0]               bresp_q;
  logic [31:0]              rdata_q;
  logic [1:0]               rresp_q;
  logic                     rvalid_q;
  logic [7:0]               ctrl_q;
  logic [7:0]               sync_mask_q;
  logic [7:0]               err_mask_q;
  logic [7:0]               sync_word_q;
  logic [7:0]               sync_word_d;
  logic [7:0]               err_word_q;
  logic [7:0]               err_word_d;
  logic [7:0]               sync_set;
  logic [7:0]               err_set;
  logic [CNT_W-1:0]         lcv_cnt_q;
  logic [CNT_W-1:0]         crc_cnt_q;
  logic [15:0]              lcv_view;
  logic [15:0]              crc_view;
  logic                     tsync_q;
  logic                     mfsync_q;
  logic                     all_ones_q;
  logic                     sig_loss_q;
  logic [4:0]               sev_hist_q;
  logic [4:0]               zero_run_q;
  logic [4:0]               zero_run_d;
  logic [4:0]               zero_thr;
  logic [tec_pkg::DENS_WIN_MAX-1:0] hist_q;
  logic [7:0]               fill_q;
  logic [tec_pkg::DENS_N_MAX-1:0]   dens_low;
  logic                     lcv_event;
  logic                     severe_event;
  logic                     density_event;
  logic                     aw_fire;
  logic                     w_fire;
  logic                     ar_fire;
  logic                     do_write;
  logic [7:0]               wr_idx;
  logic [7:0]               rd_idx;
  logic                     wr_in_range;
  logic                     rd_in_range;
  logic                     rd_sync_clr;
  logic                     rd_err_clr;

  // Handshakes and index decode
  assign s_axi_awready = (wr_state_q == tec_pkg::WR_COLLECT) && !aw_held_q;
  assign s_axi_wready  = (wr_state_q == tec_pkg::WR_COLLECT) && !w_held_q;
  assign s_axi_arready = !rvalid_q;
  assign aw_fire       = s_axi_awvalid && s_axi_awready;
  assign w_fire        = s_axi_wvalid && s_axi_wready;
  assign ar_fire       = s_axi_arvalid && s_axi_arready;
  assign do_write      = (wr_state_q == tec_pkg::WR_COLLECT) && aw_held_q && w_held_q;
  assign wr_idx        = aw_addr_q[tec_pkg::IDX_W+1:2];
  assign rd_idx        = s_axi_araddr[tec_pkg::IDX_W+1:2];
  assign wr_in_range   = (aw_addr_q >> (tec_pkg::IDX_W + 2)) == '0;
  assign rd_in_range   = (s_axi_araddr >> (tec_pkg::IDX_W + 2)) == '0;
  assign rd_sync_clr   = ar_fire && rd_in_range && rd_idx == tec_pkg::IDX_SYNC_WORD;
  assign rd_err_clr    = ar_fire && rd_in_range && rd_idx == tec_pkg::IDX_ERR_WORD;
  assign lcv_view      = 16'(lcv_cnt_q);
  assign crc_view      = 16'(crc_cnt_q);

  // Write channel: address and data taken in either order, then answered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_q <= tec_pkg::WR_COLLECT;
      aw_held_q  <= 1'b0;
      w_held_q   <= 1'b0;
      aw_addr_q  <= '0;
      wdata_q    <= 8'h00;
      wlane_q    <= 1'b0;
      bresp_q    <= tec_pkg::RESP_OKAY;
    end else begin
      case (wr_state_q)
        tec_pkg::WR_COLLECT: begin
          if (aw_fire) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
          end
          if (w_fire) begin
            w_held_q <= 1'b1;
            wdata_q  <= s_axi_wdata[7:0];
            wlane_q  <= s_axi_wstrb[0];
          end
          if (do_write) begin
            aw_held_q  <= 1'b0;
            w_held_q   <= 1'b0;
            wr_state_q <= tec_pkg::WR_RESPOND;
            bresp_q    <= reg_mapped(wr_idx, wr_in_range) ? tec_pkg::RESP_OKAY
                                                          : tec_pkg::RESP_SLVERR;
          end
        end
        tec_pkg::WR_RESPOND: begin
          if (s_axi_bready) begin
            wr_state_q <= tec_pkg::WR_COLLECT;
          end
        end
        default: wr_state_q <= tec_pkg::WR_COLLECT;
      endcase
    end
  end

  assign s_axi_bvalid = (wr_state_q == tec_pkg::WR_RESPOND);
  assign s_axi_bresp  = bresp_q;

  // Software-written control and mask bytes; byte lane 0 only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q      <= tec_pkg::CTRL_RST;
      sync_mask_q <= tec_pkg::MASK_RST;
      err_mask_q  <= tec_pkg::MASK_RST;
    end else if (do_write && wr_in_range && wlane_q) begin
      case (wr_idx)
        tec_pkg::IDX_CTRL:      ctrl_q      <= wdata_q;
        tec_pkg::IDX_SYNC_MASK: sync_mask_q <= wdata_q;
        tec_pkg::IDX_ERR_MASK:  err_mask_q  <= wdata_q;
        default: ;
      endcase
    end
  end

  // Decides whether an index answers OKAY or SLVERR
  function automatic logic reg_mapped(input logic [7:0] idx, input logic in_range);
    logic hit;
    hit = 1'b0;
    case (idx)
      tec_pkg::IDX_LCV_HIGH, tec_pkg::IDX_LCV_LOW, tec_pkg::IDX_CRC_HIGH,
      tec_pkg::IDX_CRC_LOW, tec_pkg::IDX_SYNC_WORD, tec_pkg::IDX_ERR_WORD,
      tec_pkg::IDX_CTRL, tec_pkg::IDX_SYNC_MASK, tec_pkg::IDX_ERR_MASK: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit && in_range;
  endfunction : reg_mapped

  // Read channel: data registered one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= tec_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_q <= 1'b1;
      rresp_q  <= reg_mapped(rd_idx, rd_in_range) ? tec_pkg::RESP_OKAY
                                                  : tec_pkg::RESP_SLVERR;
      case (rd_in_range ? rd_idx : 8'h00)
        tec_pkg::IDX_LCV_HIGH:  rdata_q <= {24'h0, lcv_view[15:8]};
        tec_pkg::IDX_LCV_LOW:   rdata_q <= {24'h0, lcv_view[7:0]};
        tec_pkg::IDX_CRC_HIGH:  rdata_q <= {24'h0, crc_view[15:8]};
        tec_pkg::IDX_CRC_LOW:   rdata_q <= {24'h0, crc_view[7:0]};
        tec_pkg::IDX_SYNC_WORD: rdata_q <= {24'h0, sync_word_q};
        tec_pkg::IDX_ERR_WORD:  rdata_q <= {24'h0, err_word_q};
        tec_pkg::IDX_CTRL:      rdata_q <= {24'h0, ctrl_q};
        tec_pkg::IDX_SYNC_MASK: rdata_q <= {24'h0, sync_mask_q};
        tec_pkg::IDX_ERR_MASK:  rdata_q <= {24'h0, err_mask_q};
        default:                rdata_q <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

  // Which line violations count, chosen by the excess-zero control
  assign lcv_event = (ev.bipolar_violation && !ev.violation_in_code_word)
                   || (ctrl_q[tec_pkg::CTRL_EXZ] && ev.excess_zeros);

  // Free-running wrap-around error counters
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lcv_cnt_q <= '0;
      crc_cnt_q <= '0;
    end else begin
      if (lcv_event) begin
        lcv_cnt_q <= lcv_cnt_q + 1'b1;
      end
      if (ev.crc_fail) begin
        crc_cnt_q <= crc_cnt_q + 1'b1;
      end
    end
  end

  // Previous levels for change detection, framing error history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tsync_q    <= 1'b0;
      mfsync_q   <= 1'b0;
      all_ones_q <= 1'b0;
      sig_loss_q <= 1'b0;
      sev_hist_q <= 5'h00;
    end else begin
      tsync_q    <= ev.terminal_sync;
      mfsync_q   <= ev.multiframe_sync;
      all_ones_q <= ev.all_ones;
      sig_loss_q <= ev.signal_loss;
      if (ev.framing_bit_strobe) begin
        sev_hist_q <= {sev_hist_q[3:0], ev.framing_bit_error};
      end
    end
  end

  // Second error among the last six framing bits
  assign severe_event = ev.framing_bit_strobe && ev.framing_bit_error && (|sev_hist_q);

  // Consecutive zero run, saturating
  assign zero_thr   = ctrl_q[tec_pkg::CTRL_ZSUB] ? tec_pkg::ZERO_RUN_ZSUB
                                                 : tec_pkg::ZERO_RUN_PLAIN;
  assign zero_run_d = ev.rx_bit_mark ? 5'h00
                    : (&zero_run_q) ? zero_run_q : zero_run_q + 5'h01;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      zero_run_q <= 5'h00;
      hist_q     <= '0;
      fill_q     <= 8'h00;
    end else if (ev.rx_bit_strobe) begin
      zero_run_q <= zero_run_d;
      hist_q     <= {hist_q[tec_pkg::DENS_WIN_MAX-2:0], ev.rx_bit_mark};
      if (fill_q != 8'(tec_pkg::DENS_WIN_MAX)) begin
        fill_q <= fill_q + 8'h01;
      end
    end
  end

  // Sliding ones count over 8(N+1) bits for each N
  for (genvar n = 1; n <= tec_pkg::DENS_N_MAX; n++) begin : g_dens
    localparam int unsigned WIN = 8 * (n + 1);
    logic [7:0] ones_q;
    logic [7:0] ones_d;
    assign ones_d = ones_q + {7'h00, ev.rx_bit_mark} - {7'h00, hist_q[WIN-1]};
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ones_q <= 8'h00;
      end else if (ev.rx_bit_strobe) begin
        ones_q <= ones_d;
      end
    end
    assign dens_low[n-1] = (fill_q >= 8'(WIN - 1)) && (ones_d < 8'(n));
  end

  // Zero runs always, density only without zero substitution
  assign density_event = ev.rx_bit_strobe
                       && ((!ev.rx_bit_mark && zero_run_d == zero_thr)
                           || (!ctrl_q[tec_pkg::CTRL_ZSUB] && (|dens_low)));

  // Raw event vectors for the two words
  always_comb begin
    sync_set                       = 8'h00;
    sync_set[tec_pkg::SW_TSYNC]    = ev.terminal_sync != tsync_q;
    sync_set[tec_pkg::SW_MFSYNC]   = ev.multiframe_sync != mfsync_q;
    sync_set[tec_pkg::SW_LINK_MSG] = ev.bit_oriented_link_message_new
                                   || ev.bit_oriented_link_message_stop;
    sync_set[tec_pkg::SW_ALL_ONES] = ev.all_ones != all_ones_q;
    sync_set[tec_pkg::SW_SIG_LOSS] = ev.signal_loss != sig_loss_q;
    sync_set[tec_pkg::SW_SEVERE]   = severe_event;
    sync_set[tec_pkg::SW_TX_SLIP]  = ev.tx_slip;
    sync_set[tec_pkg::SW_RX_SLIP]  = ev.rx_slip;
    err_set                        = 8'h00;
    err_set[tec_pkg::EW_FBIT]      = ev.framing_bit_strobe && ev.framing_bit_error
                                   && ev.terminal_sync;
    err_set[tec_pkg::EW_CRC]       = ev.crc_fail;
    err_set[tec_pkg::EW_YELLOW]    = ev.yellow_alarm;
    err_set[tec_pkg::EW_ALIGN]     = ev.reframe_shifted;
    err_set[tec_pkg::EW_LCV]       = lcv_event;
    err_set[tec_pkg::EW_PRBS]      = ev.test_sequence_error;
    err_set[tec_pkg::EW_DENSITY]   = density_event;
  end

  // Read clears, a same-cycle unmasked event still sets
  assign sync_word_d = (sync_word_q & ~{8{rd_sync_clr}}) | (sync_set & sync_mask_q);
  assign err_word_d  = ((err_word_q & ~{8{rd_err_clr}}) | (err_set & err_mask_q))
                     & tec_pkg::ERR_USED;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_word_q <= 8'h00;
      err_word_q  <= 8'h00;
    end else begin
      sync_word_q <= sync_word_d;
      err_word_q  <= err_word_d;
    end
  end

  // Interrupt level follows the pending bits
  assign event_irq = (|sync_word_q) || (|err_word_q);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_second_fbit_err;
    ev.framing_bit_strobe && ev.framing_bit_error && (|sev_hist_q);
  endsequence

  sequence s_read_sync_idle;
    rd_sync_clr && sync_set == 8'h00;
  endsequence

  a_lcv_exz_count: assert property (ctrl_q[tec_pkg::CTRL_EXZ] && ev.excess_zeros
      |=> lcv_cnt_q == $past(lcv_cnt_q) + 1'b1)
    else $error("excess zeros not counted while enabled");
  a_lcv_code_word: assert property (!ctrl_q[tec_pkg::CTRL_EXZ] && !ev.excess_zeros
      && (!ev.bipolar_violation || ev.violation_in_code_word) |=> $stable(lcv_cnt_q))
    else $error("line violation count moved without a counted violation");
  a_lcv_low_read: assert property (ar_fire && rd_idx == tec_pkg::IDX_LCV_LOW
      && rd_in_range |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(lcv_view[7:0]))
    else $error("low violation byte read wrong");
  a_lcv_high_read: assert property (ar_fire && rd_idx == tec_pkg::IDX_LCV_HIGH
      && rd_in_range |=> s_axi_rdata == {24'h0, $past(lcv_view[15:8])})
    else $error("high violation byte read wrong");
  a_crc_count_step: assert property (ev.crc_fail
      |=> crc_cnt_q == $past(crc_cnt_q) + 1'b1)
    else $error("CRC-6 error count did not step");
  a_mask_blocks_set: assert property (!sync_mask_q[tec_pkg::SW_TX_SLIP]
      && !sync_word_q[tec_pkg::SW_TX_SLIP] |=> !sync_word_q[tec_pkg::SW_TX_SLIP])
    else $error("masked slip bit was set");
  a_read_clears_word: assert property (s_read_sync_idle |=> sync_word_q == 8'h00)
    else $error("sync word not cleared by read");
  a_tsync_change: assert property (sync_mask_q[tec_pkg::SW_TSYNC]
      && ev.terminal_sync != $past(ev.terminal_sync) ##1 1'b1
      |-> sync_word_q[tec_pkg::SW_TSYNC])
    else $error("terminal sync change not flagged");
  a_severe_frame: assert property (s_second_fbit_err and sync_mask_q[tec_pkg::SW_SEVERE]
      |=> sync_word_q[tec_pkg::SW_SEVERE])
    else $error("second framing error in six not flagged");
  a_fbit_out_sync: assert property (!err_word_q[tec_pkg::EW_FBIT] && !ev.terminal_sync
      |=> !err_word_q[tec_pkg::EW_FBIT])
    else $error("framing error flagged out of sync");
  a_unused_zero: assert property (!err_word_q[tec_pkg::EW_UNUSED])
    else $error("unused error bit set");
  a_irq_follows: assert property (event_irq == ((sync_word_q | err_word_q) != 8'h00))
    else $error("interrupt output disagrees with pending bits");

endmodule : tec_error_counters

// [tec_line_model.sv]
// Behavioural source of receive line events for the counter block.
// Assumes its tasks are called just after a rising edge of aclk.
module tec_line_model (
  input  wire logic            aclk,
  output tec_pkg::tec_events_s ev
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet line: no pulses, no levels held; the bench calls it at time zero
  task automatic idle();
    ev <= '0;
  endtask : idle
  // One-cycle event, then one quiet cycle so pulses never merge
  task automatic pulse(input logic [18:0] m);
    ev <= ev | m;
    @(posedge aclk);
    ev <= ev & ~m;
    @(posedge aclk);
  endtask : pulse
  // Level that stays until a later pulse on the same bit drops it
  task automatic hold(input logic [18:0] m);
    ev <= ev | m;
    @(posedge aclk);
  endtask : hold
endmodule : tec_line_model

// [test_t1_error_counters_and_interrupts.sv]
// Bench for the receive error counters and event words over AXI4-Lite.
// Assumes tec_pkg, tec_error_counters and tec_line_model compiled first.
module test_t1_error_counters_and_interrupts;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 aclk, aresetn;
  logic [11:0]          s_axi_awaddr, s_axi_araddr;
  logic [31:0]          s_axi_wdata, s_axi_rdata, rd_q;
  logic [3:0]           s_axi_wstrb;
  logic [1:0]           s_axi_bresp, s_axi_rresp, resp_q;
  logic                 s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic                 s_axi_arvalid, s_axi_rready, s_axi_rvalid;
  logic                 s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, event_irq;
  tec_pkg::tec_events_s ev;
  int                   compares = 0, miscompares = 0;
  // Event per entry and the word value it must leave; first eight hit the sync word
  logic [18:0] ev_t [12] = '{19'h40000, 19'h20000, 19'h10000, 19'h08000, 19'h04000,
    19'h02000, 19'h00400, 19'h00200, 19'h01800, 19'h00080, 19'h00040, 19'h00004};
  logic [7:0]  ex_t [12] = '{8'h80, 8'h40, 8'h20, 8'h20, 8'h10, 8'h08, 8'h02, 8'h01,
    8'h80, 8'h20, 8'h10, 8'h04};
  // 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  tec_error_counters dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ev, .event_irq);
  tec_line_model line_u (.aclk, .ev);
  // Verdict and end of run
  task automatic summarize();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  // Value comparison, four-state exact
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // A wait that used up its bound ends the run
  task automatic lim(input int n);
    if (n >= 50) begin
      miscompares++;
      summarize();
    end
  endtask : lim
  // AXI write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    int n = 0;
    s_axi_awaddr  <= {2'h0, i, 2'h0};
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid  <= 1;
    s_axi_bready  <= 1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    resp_q = s_axi_bresp;
    s_axi_bready <= 0;
    lim(n);
    // One quiet edge so the next call never reassigns bready in this step
    @(posedge aclk);
  endtask : wr
  // AXI read of one register, then comparison of its data
  task automatic rc(input logic [7:0] i, input logic [7:0] e);
    int n = 0;
    s_axi_araddr  <= {2'h0, i, 2'h0};
    s_axi_arvalid <= 1;
    s_axi_rready  <= 1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    rd_q = s_axi_rdata;
    resp_q = s_axi_rresp;
    s_axi_rready <= 0;
    lim(n);
    // One quiet edge so the next call never reassigns rready in this step
    @(posedge aclk);
    chk($sformatf("reg %h", i), {24'h0, e}, rd_q);
  endtask : rc
  // Main sequence
  initial begin
    aresetn       <= 1'b0;
    s_axi_awaddr  <= '0;
    s_axi_araddr  <= '0;
    s_axi_wdata   <= '0;
    s_axi_wstrb   <= 4'h1;
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    s_axi_bready  <= 1'b0;
    s_axi_arvalid <= 1'b0;
    s_axi_rready  <= 1'b0;
    line_u.idle();
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rc(tec_pkg::IDX_SYNC_WORD, 8'h00);
    chk("irq", 0, event_irq);
    line_u.pulse(19'h00020);
    line_u.pulse(19'h00030);
    line_u.pulse(19'h00008);
    wr(tec_pkg::IDX_CTRL, 8'h01);
    line_u.pulse(19'h00008);
    rc(tec_pkg::IDX_LCV_LOW, 8'h02);
    rc(tec_pkg::IDX_LCV_HIGH, 8'h00);
    rc(tec_pkg::IDX_ERR_WORD, 8'h08);
    rc(tec_pkg::IDX_ERR_WORD, 8'h00);
    chk("irq", 0, event_irq);
    wr(tec_pkg::IDX_SYNC_MASK, 8'h00);
    line_u.pulse(19'h00200);
    rc(tec_pkg::IDX_SYNC_WORD, 8'h00);
    wr(tec_pkg::IDX_SYNC_MASK, 8'hff);
    repeat (257) line_u.pulse(19'h00100);
    rc(tec_pkg::IDX_CRC_HIGH, 8'h01);
    rc(tec_pkg::IDX_CRC_LOW, 8'h01);
    rc(tec_pkg::IDX_ERR_WORD, 8'h40);
    repeat (2) line_u.pulse(19'h01800);
    rc(tec_pkg::IDX_SYNC_WORD, 8'h04);
    rc(tec_pkg::IDX_ERR_WORD, 8'h00);
    for (int i = 0; i < 12; i++) begin
      if (i == 8) line_u.hold(19'h40000);
      line_u.pulse(ev_t[i]);
      chk("irq", 1, event_irq);
      rc(i < 8 ? tec_pkg::IDX_SYNC_WORD : tec_pkg::IDX_ERR_WORD, ex_t[i]);
    end
    repeat (16) line_u.pulse(19'h00002);
    rc(tec_pkg::IDX_ERR_WORD, 8'h02);
    wr(tec_pkg::IDX_CTRL, 8'h02);
    line_u.pulse(19'h00003);
    repeat (8) line_u.pulse(19'h00002);
    rc(tec_pkg::IDX_ERR_WORD, 8'h02);
    // Sparse ones, runs of 14 zeros: only the density window can flag
    wr(tec_pkg::IDX_CTRL, 8'h00);
    repeat (2) begin
      line_u.pulse(19'h00003);
      repeat (14) line_u.pulse(19'h00002);
    end
    rc(tec_pkg::IDX_ERR_WORD, 8'h02);
    // Write with byte lane 0 off is answered but ignored
    s_axi_wstrb <= 4'h0;
    wr(tec_pkg::IDX_ERR_MASK, 8'h00);
    chk("bresp", {30'h0, tec_pkg::RESP_OKAY}, {30'h0, resp_q});
    s_axi_wstrb <= 4'h1;
    rc(tec_pkg::IDX_ERR_MASK, 8'hff);
    rc(8'h00, 8'h00);
    chk("rresp", {30'h0, tec_pkg::RESP_SLVERR}, {30'h0, resp_q});
    wr(8'h00, 8'h00);
    chk("bresp", {30'h0, tec_pkg::RESP_SLVERR}, {30'h0, resp_q});
    summarize();
  end
endmodule : test_t1_error_counters_and_interrupts
